// >>> rtl/pvq_map.vh
// Register indices, field positions and fixed values of the per-port VLAN and queue controls.
`ifndef PVQ_MAP_VH
`define PVQ_MAP_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define PVQ_IDX_P1_VLAN    8'hB0
`define PVQ_IDX_P1_QUEUE   8'hB1
`define PVQ_IDX_P2_VLAN    8'hC0
`define PVQ_IDX_P2_QUEUE   8'hC1
`define PVQ_IDX_P3_VLAN    8'hD0
`define PVQ_IDX_P3_QUEUE   8'hD1
`define PVQ_IDX_RSVD_A     8'hE0
`define PVQ_IDX_RSVD_B     8'hE1
`define PVQ_IDX_P4_VLAN    8'hF0
`define PVQ_IDX_P4_QUEUE   8'hF1

// ==========================================================================
// Field positions
`define PVQ_VL_PASS_ALL    6
`define PVQ_VL_INS_HI      3
`define PVQ_VL_INS_SH      2
`define PVQ_VL_INS_MID     1
`define PVQ_VL_INS_LO      0
`define PVQ_QS_FOUR        1

// ==========================================================================
// Write masks, fixed read values and reset values
`define PVQ_VL_WMASK_P123  8'h4B
`define PVQ_VL_WMASK_P4    8'h47
`define PVQ_VL_FIXED       8'h80
`define PVQ_QS_WMASK       8'h02
`define PVQ_QS_FIXED       8'h00
`define PVQ_RSVD_VALUE     8'h00
`define PVQ_RST_VALUE      8'h00

// ==========================================================================
// Queue split codes
`define PVQ_QCODE_ONE      2'b00
`define PVQ_QCODE_TWO      2'b01
`define PVQ_QCODE_FOUR     2'b10
`define PVQ_QCODE_RSVD     2'b11

`endif

// >>> rtl/pvq_ctrl_reg.v
// One 8-bit control register with fixed reserved bits.
`timescale 1ns/1ns

module pvq_ctrl_reg #(
    parameter [7:0] WMASK = 8'hFF,
    parameter [7:0] FIXED = 8'h00
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Write port
    input  wire       wr_en,
    input  wire [7:0] wdata,
    // Read value
    output wire [7:0] rdata
);

`include "pvq_map.vh"

    reg [7:0] value_reg;

    // ======================================================================
    // Storage
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= `PVQ_RST_VALUE;
        end else if (wr_en) begin
            value_reg <= wdata & WMASK;
        end
    end

    // Reserved bits never reach storage, so they always show their fixed value.
    assign rdata = (value_reg & WMASK) | (FIXED & ~WMASK);

endmodule // pvq_ctrl_reg

// >>> rtl/pvq_queue_sel.v
// Queue split decode and per-frame transmit queue selection for one port.
`timescale 1ns/1ns

module pvq_queue_sel (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Split code sources
    input  wire       four_en,
    input  wire       split_lo,
    // Frame priority
    input  wire [1:0] frame_prio,
    // Results
    output reg  [1:0] queue_code,
    output reg  [1:0] queue_idx,
    output reg        prio_order_en,
    output reg        code_rsvd
);

`include "pvq_map.vh"

    wire [1:0] code_now;

    assign code_now = {four_en, split_lo};

    // ======================================================================
    // Decode
    // The reserved code is treated as a single queue so frames are never lost.
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            queue_code    <= `PVQ_QCODE_ONE;
            queue_idx     <= 2'h0;
            prio_order_en <= 1'b0;
            code_rsvd     <= 1'b0;
        end else begin
            queue_code <= code_now;
            case (code_now)
                `PVQ_QCODE_FOUR: begin
                    queue_idx     <= frame_prio;
                    prio_order_en <= 1'b1;
                    code_rsvd     <= 1'b0;
                end
                `PVQ_QCODE_TWO: begin
                    queue_idx     <= {1'b0, frame_prio[1]};
                    prio_order_en <= 1'b1;
                    code_rsvd     <= 1'b0;
                end
                `PVQ_QCODE_RSVD: begin
                    queue_idx     <= 2'h0;
                    prio_order_en <= 1'b0;
                    code_rsvd     <= 1'b1;
                end
                default: begin
                    queue_idx     <= 2'h0;
                    prio_order_en <= 1'b0;
                    code_rsvd     <= 1'b0;
                end
            endcase
        end
    end

endmodule // pvq_queue_sel

// >>> rtl/pvq_port_ctrl.v
// Per-port pass-all, default VLAN ID insertion and queue split control with APB access.
//
// Contract
// - Set pass-all bit forwards every frame on that port, used with receive sniffing; the code overrides a drop only while that port's rx_sniff_en is set.
// - Bit 3 of ports 1-3 inserts source default VLAN ID toward port 4.
// - Bit 2 only for port 4: insert its default VLAN ID toward port 3.
// - Bit 1 inserts: 1 to 3, 2 to 3, 3 to 2, 4 to 2.
// - Bit 0 inserts: 1 to 2, 2 to 1, 3 to 1, 4 to 1.
// - Every insertion bit works only while the global insertion enable is set.
// - Split code is four-queue bit over companion bit: 10 four, 01 two, 11 reserved.
// - Code 00 uses one queue with no priority ordering.
//
// The APB register port was decided locally.
`timescale 1ns/1ns

module pvq_port_ctrl (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire [31:0] prdata,
    output wire        pslverr,
    // Switch core controls
    input  wire        glb_pvid_ins_en,
    input  wire [3:0]  queue_split_lo,
    input  wire [3:0]  rx_sniff_en,
    // Receive filter
    input  wire [3:0]  rx_drop_req,
    output wire [3:0]  rx_forward,
    // Egress tag lookup
    input  wire        eg_valid,
    input  wire [1:0]  eg_src_port,
    input  wire [1:0]  eg_dst_port,
    input  wire        eg_untagged,
    output wire        eg_ins_valid,
    output wire        eg_ins_pvid,
    // Per-port settings
    output wire [3:0]  pass_all,
    output wire [15:0] pvid_ins_map,
    // Transmit queue selection
    input  wire [7:0]  frame_prio,
    output wire [7:0]  queue_code,
    output wire [7:0]  queue_idx,
    output wire [3:0]  prio_order_en,
    output wire [3:0]  queue_code_rsvd
);

`include "pvq_map.vh"

    // ======================================================================
    // Declarations
    wire [31:0] vl_rd;
    wire [31:0] qs_rd;
    wire [15:0] ins_raw;
    wire        acc_wr;
    wire        setup;
    reg  [7:0]  rd_mux;
    reg         rd_hit;
    reg  [7:0]  prdata_reg;
    reg         pslverr_reg;
    reg  [3:0]  rx_forward_reg;
    reg  [3:0]  pass_all_reg;
    reg  [15:0] pvid_ins_map_reg;
    reg         eg_ins_valid_reg;
    reg         eg_ins_pvid_reg;

    // ======================================================================
    // APB handshake
    // Read data is captured in the setup cycle, so the access phase never waits.
    assign pready  = 1'b1;
    assign setup   = psel & ~penable;
    assign acc_wr  = psel & penable & pwrite & pstrb[0] & rd_hit;
    assign prdata  = {24'h000000, prdata_reg};
    assign pslverr = pslverr_reg;

    // ======================================================================
    // Address decode and read multiplexer
    always @* begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
        if (paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00) begin
            rd_hit = 1'b1;
            case (paddr[9:2])
                `PVQ_IDX_P1_VLAN:  rd_mux = vl_rd[7:0];
                `PVQ_IDX_P1_QUEUE: rd_mux = qs_rd[7:0];
                `PVQ_IDX_P2_VLAN:  rd_mux = vl_rd[15:8];
                `PVQ_IDX_P2_QUEUE: rd_mux = qs_rd[15:8];
                `PVQ_IDX_P3_VLAN:  rd_mux = vl_rd[23:16];
                `PVQ_IDX_P3_QUEUE: rd_mux = qs_rd[23:16];
                `PVQ_IDX_RSVD_A:   rd_mux = `PVQ_RSVD_VALUE;
                `PVQ_IDX_RSVD_B:   rd_mux = `PVQ_RSVD_VALUE;
                `PVQ_IDX_P4_VLAN:  rd_mux = vl_rd[31:24];
                `PVQ_IDX_P4_QUEUE: rd_mux = qs_rd[31:24];
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 8'h00;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg  <= pwrite ? 8'h00 : rd_mux;
            pslverr_reg <= ~rd_hit;
        end
    end

    // ======================================================================
    // Per-port registers and queue selection
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            localparam [7:0] VIDX  = (p == 0) ? `PVQ_IDX_P1_VLAN :
                                     (p == 1) ? `PVQ_IDX_P2_VLAN :
                                     (p == 2) ? `PVQ_IDX_P3_VLAN : `PVQ_IDX_P4_VLAN;
            localparam [7:0] QIDX  = (p == 0) ? `PVQ_IDX_P1_QUEUE :
                                     (p == 1) ? `PVQ_IDX_P2_QUEUE :
                                     (p == 2) ? `PVQ_IDX_P3_QUEUE : `PVQ_IDX_P4_QUEUE;
            // Port 4 owns bit 2 and lacks bit 3; the others the reverse.
            localparam [7:0] VMASK = (p == 3) ? `PVQ_VL_WMASK_P4 : `PVQ_VL_WMASK_P123;

            pvq_ctrl_reg #(
                .WMASK (VMASK),
                .FIXED (`PVQ_VL_FIXED)
            ) u_vlan (
                .mclk  (mclk),
                .rst_n (rst_n),
                .wr_en (acc_wr & (paddr[9:2] == VIDX)),
                .wdata (pwdata[7:0]),
                .rdata (vl_rd[8*p+7:8*p])
            );

            pvq_ctrl_reg #(
                .WMASK (`PVQ_QS_WMASK),
                .FIXED (`PVQ_QS_FIXED)
            ) u_queue (
                .mclk  (mclk),
                .rst_n (rst_n),
                .wr_en (acc_wr & (paddr[9:2] == QIDX)),
                .wdata (pwdata[7:0]),
                .rdata (qs_rd[8*p+7:8*p])
            );

            pvq_queue_sel u_qsel (
                .mclk          (mclk),
                .rst_n         (rst_n),
                .four_en       (qs_rd[8*p+`PVQ_QS_FOUR]),
                .split_lo      (queue_split_lo[p]),
                .frame_prio    (frame_prio[2*p+1:2*p]),
                .queue_code    (queue_code[2*p+1:2*p]),
                .queue_idx     (queue_idx[2*p+1:2*p]),
                .prio_order_en (prio_order_en[p]),
                .code_rsvd     (queue_code_rsvd[p])
            );
        end
    endgenerate

    // ======================================================================
    // Insertion map, index is source port times four plus egress port
    assign ins_raw[0]  = 1'b0;
    assign ins_raw[1]  = vl_rd[`PVQ_VL_INS_LO];
    assign ins_raw[2]  = vl_rd[`PVQ_VL_INS_MID];
    assign ins_raw[3]  = vl_rd[`PVQ_VL_INS_HI];
    assign ins_raw[4]  = vl_rd[8+`PVQ_VL_INS_LO];
    assign ins_raw[5]  = 1'b0;
    assign ins_raw[6]  = vl_rd[8+`PVQ_VL_INS_MID];
    assign ins_raw[7]  = vl_rd[8+`PVQ_VL_INS_HI];
    assign ins_raw[8]  = vl_rd[16+`PVQ_VL_INS_LO];
    assign ins_raw[9]  = vl_rd[16+`PVQ_VL_INS_MID];
    assign ins_raw[10] = 1'b0;
    assign ins_raw[11] = vl_rd[16+`PVQ_VL_INS_HI];
    assign ins_raw[12] = vl_rd[24+`PVQ_VL_INS_LO];
    assign ins_raw[13] = vl_rd[24+`PVQ_VL_INS_MID];
    assign ins_raw[14] = vl_rd[24+`PVQ_VL_INS_SH];
    assign ins_raw[15] = 1'b0;

    // ======================================================================
    // Registered outputs
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pass_all_reg     <= 4'h0;
            rx_forward_reg   <= 4'h0;
            pvid_ins_map_reg <= 16'h0000;
            eg_ins_valid_reg <= 1'b0;
            eg_ins_pvid_reg  <= 1'b0;
        end else begin
            pass_all_reg <= {vl_rd[24+`PVQ_VL_PASS_ALL], vl_rd[16+`PVQ_VL_PASS_ALL],
                             vl_rd[8+`PVQ_VL_PASS_ALL], vl_rd[`PVQ_VL_PASS_ALL]};
            // Pass-all only overrides the drop request on a sniffing port.
            rx_forward_reg <= ~rx_drop_req |
                              (rx_sniff_en & {vl_rd[24+`PVQ_VL_PASS_ALL],
                                              vl_rd[16+`PVQ_VL_PASS_ALL],
                                              vl_rd[8+`PVQ_VL_PASS_ALL],
                                              vl_rd[`PVQ_VL_PASS_ALL]});
            pvid_ins_map_reg <= glb_pvid_ins_en ? ins_raw : 16'h0000;
            eg_ins_valid_reg <= eg_valid;
            eg_ins_pvid_reg  <= eg_valid & eg_untagged & glb_pvid_ins_en &
                                ins_raw[{eg_src_port, eg_dst_port}];
        end
    end

    assign pass_all     = pass_all_reg;
    assign rx_forward   = rx_forward_reg;
    assign pvid_ins_map = pvid_ins_map_reg;
    assign eg_ins_valid = eg_ins_valid_reg;
    assign eg_ins_pvid  = eg_ins_pvid_reg;

endmodule // pvq_port_ctrl

// >>> sim/pvq_port_ctrl_assertions.sv
// Concurrent checks on the pass-all, insertion map and queue split outputs.
`timescale 1ns/1ns

module pvq_port_ctrl_chk (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Inputs watched
    input wire logic        glb_pvid_ins_en,
    input wire logic        eg_valid,
    input wire logic        eg_untagged,
    input wire logic [1:0]  eg_src_port,
    input wire logic [1:0]  eg_dst_port,
    input wire logic [3:0]  queue_split_lo,
    input wire logic [3:0]  rx_sniff_en,
    input wire logic [3:0]  rx_drop_req,
    input wire logic [7:0]  frame_prio,
    // Outputs watched
    input wire logic        eg_ins_pvid,
    input wire logic [3:0]  rx_forward,
    input wire logic [3:0]  pass_all,
    input wire logic [3:0]  prio_order_en,
    input wire logic [3:0]  queue_code_rsvd,
    input wire logic [7:0]  queue_code,
    input wire logic [7:0]  queue_idx,
    input wire logic [15:0] pvid_ins_map
);
    // ==========================================================================
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // The map is only trusted while it held still, so a write in flight cannot fire this.
    property p_ins_hit;
        $past(rst_n && glb_pvid_ins_en && eg_valid && eg_untagged) && $stable(pvid_ins_map)
            && $past(pvid_ins_map[{eg_src_port, eg_dst_port}]) |-> eg_ins_pvid;
    endproperty
    // The pass-all output lags its register by one cycle, as the forward mask does,
    // so it is compared in the same cycle while the request inputs are taken one back.
    property p_pass_fwd;
        $past(rst_n) |-> rx_forward == (~$past(rx_drop_req) | ($past(rx_sniff_en) & pass_all));
    endproperty
    property p_ins_glb;
        $past(rst_n) && !$past(glb_pvid_ins_en) |-> pvid_ins_map == 16'h0000;
    endproperty
    property p_q_lo;
        $past(rst_n) |-> {queue_code[6], queue_code[4], queue_code[2], queue_code[0]}
            == $past(queue_split_lo);
    endproperty
    property p_q_rsvd;
        queue_code_rsvd == {&queue_code[7:6], &queue_code[5:4], &queue_code[3:2],
            &queue_code[1:0]};
    endproperty
    property p_q_order;
        prio_order_en == {^queue_code[7:6], ^queue_code[5:4], ^queue_code[3:2],
            ^queue_code[1:0]};
    endproperty
    property p_q_one;
        queue_code[1:0] == 2'b00 |-> queue_idx[1:0] == 2'b00;
    endproperty
    property p_q_four;
        $past(rst_n) && queue_code[3:2] == 2'b10 |-> queue_idx[3:2] == $past(frame_prio[3:2]);
    endproperty
    property p_q_two;
        $past(rst_n) && queue_code[5:4] == 2'b01
            |-> queue_idx[5:4] == {1'b0, $past(frame_prio[5])};
    endproperty

    // ==========================================================================
    // Assertions and covers
    a_ins_hit: assert property (p_ins_hit) else $error("insertion flag missing");
    a_pass_fwd: assert property (p_pass_fwd) else $error("forward mask wrong");
    a_ins_glb: assert property (p_ins_glb) else $error("map set while disabled");
    a_q_lo: assert property (p_q_lo) else $error("split code low bit wrong");
    a_q_rsvd: assert property (p_q_rsvd) else $error("reserved code flag wrong");
    a_q_order: assert property (p_q_order) else $error("priority ordering wrong");
    a_q_one: assert property (p_q_one) else $error("single queue index wrong");
    a_q_four: assert property (p_q_four) else $error("four queue index wrong");
    a_q_two: assert property (p_q_two) else $error("two queue index wrong");
    c_hit: cover property (eg_ins_pvid);
    c_four: cover property (queue_code[3:2] == 2'b10);
    c_pass: cover property (|(pass_all & rx_sniff_en));
endmodule // pvq_port_ctrl_chk

bind pvq_port_ctrl pvq_port_ctrl_chk i_pvq_port_ctrl_chk (
    .mclk(mclk), .rst_n(rst_n), .glb_pvid_ins_en(glb_pvid_ins_en), .eg_valid(eg_valid),
    .eg_untagged(eg_untagged), .eg_src_port(eg_src_port), .eg_dst_port(eg_dst_port),
    .queue_split_lo(queue_split_lo), .rx_sniff_en(rx_sniff_en), .rx_drop_req(rx_drop_req),
    .frame_prio(frame_prio), .eg_ins_pvid(eg_ins_pvid), .rx_forward(rx_forward),
    .pass_all(pass_all), .prio_order_en(prio_order_en), .queue_code_rsvd(queue_code_rsvd),
    .queue_code(queue_code), .queue_idx(queue_idx), .pvid_ins_map(pvid_ins_map)
);

// >>> sim/pvq_port_ctrl_tb_top.sv
// Self-checking testbench for the per-port VLAN insertion and queue split controls.
`timescale 1ns/1ns

module pvq_port_ctrl_tb_top;
    // ==========================================================================
    // Signals and design
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, glb, eg_v, eg_u;
    logic        eg_iv, eg_ip, err;
    logic [1:0]  eg_s, eg_d;
    logic [3:0]  pstrb, qlo, sniff, drop, fwd, pall, porder, qrsvd;
    logic [7:0]  prio, qcode, qidx;
    logic [11:0] paddr;
    logic [15:0] pmap;
    logic [31:0] pwdata, prdata, rd;
    int          miscompares, n_checks, k, b;
    logic [7:0]  regs [10] = '{8'hB0, 8'hB1, 8'hC0, 8'hC1, 8'hD0,
                               8'hD1, 8'hE0, 8'hE1, 8'hF0, 8'hF1};
    logic [7:0]  rstv [10] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h80,
                               8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    logic [7:0]  fullv [10] = '{8'hCB, 8'h02, 8'hCB, 8'h02, 8'hCB,
                                8'h02, 8'h00, 8'h00, 8'hC7, 8'h02};
    logic [7:0]  vl [4] = '{8'hB0, 8'hC0, 8'hD0, 8'hF0};
    logic [7:0]  ql [4] = '{8'hB1, 8'hC1, 8'hD1, 8'hF1};
    logic [15:0] mapx [4] = '{16'h1112, 16'h2244, 16'h4000, 16'h0888};

    pvq_port_ctrl i_pvq_port_ctrl (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .glb_pvid_ins_en(glb), .queue_split_lo(qlo), .rx_sniff_en(sniff),
        .rx_drop_req(drop), .rx_forward(fwd), .eg_valid(eg_v), .eg_src_port(eg_s),
        .eg_dst_port(eg_d), .eg_untagged(eg_u), .eg_ins_valid(eg_iv), .eg_ins_pvid(eg_ip),
        .pass_all(pall), .pvid_ins_map(pmap), .frame_prio(prio), .queue_code(qcode),
        .queue_idx(qidx), .prio_order_en(porder), .queue_code_rsvd(qrsvd)
    );

    // ==========================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One APB transfer; an idle cycle follows so the next setup never collides with release.
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        input logic [3:0] s);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, d};
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            $display("MISMATCH %0t pready timeout", $time);
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d, 4'h1);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic e);
        xfer(1'b0, idx, 8'h00, 4'hF);
        chk(rd, {24'h000000, exp});
        chk(err, e);
    endtask
    task automatic look;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
    endtask

    // ==========================================================================
    // Sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {rst_n, psel, penable, pwrite, glb, eg_v, eg_u, eg_s, eg_d} = '0;
        {pstrb, qlo, sniff, drop, prio, paddr, pwdata} = '0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (k = 0; k < 10; k++) rdc(regs[k], rstv[k], 1'b0);
        for (k = 0; k < 10; k++) begin
            wr(regs[k], 8'hFF);
            rdc(regs[k], fullv[k], 1'b0);
        end
        xfer(1'b1, 8'hB0, 8'h00, 4'h0);
        rdc(8'hB0, 8'hCB, 1'b0);
        rdc(8'h10, 8'h00, 1'b1);
        glb <= 1'b1;
        for (b = 0; b < 4; b++) begin
            for (k = 0; k < 4; k++) wr(vl[k], 8'h01 << b);
            look;
            chk(pmap, mapx[b]);
            @(posedge mclk);
        end
        eg_v <= 1'b1;
        eg_u <= 1'b1;
        eg_s <= 2'd1;
        eg_d <= 2'd3;
        look;
        chk({eg_iv, eg_ip}, 2'b11);
        @(posedge mclk);
        glb <= 1'b0;
        look;
        chk({pmap, eg_ip}, 17'h00000);
        @(posedge mclk);
        glb <= 1'b1;
        eg_u <= 1'b0;
        look;
        chk(eg_ip, 1'b0);
        @(posedge mclk);
        for (k = 0; k < 4; k++) wr(vl[k], 8'h40);
        drop <= 4'hF;
        sniff <= 4'h5;
        look;
        chk({pall, fwd}, 8'hF5);
        @(posedge mclk);
        drop <= 4'h6;
        sniff <= 4'h0;
        look;
        chk(fwd, 4'h9);
        @(posedge mclk);
        wr(ql[2], 8'h00);
        wr(ql[3], 8'h00);
        qlo <= 4'h5;
        prio <= 8'hFB;
        look;
        chk({qcode, qidx, porder, qrsvd}, 24'h1B1861);
        stop_test();
    end
endmodule // pvq_port_ctrl_tb_top
